// [idi_dma_irq.sv]
// Purpose: DMA handshake gating and ISA interrupt line drive
// Assumes: Core-side inputs on clk; ISA pins asynchronous
// Notes:   Pins are split into out and active-low output enable
//
// Operation
// (R1) Floppy request driven only when gate bit set
// (R2) Floppy ack qualifies strobes, gated alike
// (R3) Parallel request negated outside ECP hardware mode
// (R4) ECP mode: request tri-stated unless extended-control bit
// (R5) Parallel ack qualifies strobes, extended-control gated
// (R6) Terminal count accepted only with an ack
// (R7) Lines 3 and 4 serial, polarity selectable
// (R8) Hardware config: line follows serial address
// (R9) Software config: line chosen independently
// (R10) Serial lines enabled by modem control, else tri-stated
// (R11) Parallel uses line 5 or 7, other tri-stated
// (R12) Hardware config: 278h uses 5, else 7
// (R13) Line 6 floppy, polarity, data-ready in non-DMA
// (R14) Line 6 also on execution phase done
// (R15) Line 6 tri-stated while gate bit clear
// (R16) AEN with ack marks DMA cycle, no I/O
// (R17) No zero-wait end on DMA accesses
// (R18) Polarity affects driven levels only
`timescale 1ns/1ps
`default_nettype none
module idi_dma_irq (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [2:0]       reg_addr,
    input  wire logic [7:0]       reg_wdata,
    input  wire logic             reg_write,
    input  wire logic             reg_read,
    output logic [7:0]            reg_rdata,
    input  wire idi_pkg::idi_isa_s isa_pins,
    input  wire logic             io_decoded,
    input  wire logic             fdc_dma_want,
    input  wire logic             fdc_non_dma,
    input  wire logic             fdc_data_ready,
    input  wire logic             fdc_exec_done,
    input  wire logic             par_dma_want,
    input  wire logic             par_irq,
    input  wire logic             ser_a_irq,
    input  wire logic             ser_a_out2,
    input  wire logic [1:0]       ser_a_base,
    input  wire logic             ser_b_irq,
    input  wire logic             ser_b_out2,
    input  wire logic [1:0]       ser_b_base,
    input  wire logic [1:0]       par_base,
    output idi_pkg::idi_pin_s     floppy_dma_request,
    output idi_pkg::idi_pin_s     parport_dma_request,
    output idi_pkg::idi_pin_s     irq3,
    output idi_pkg::idi_pin_s     irq4,
    output idi_pkg::idi_pin_s     irq5,
    output idi_pkg::idi_pin_s     irq6,
    output idi_pkg::idi_pin_s     irq7,
    output idi_pkg::idi_pin_s     zero_wait_end_n,
    output logic                  fdc_dma_read,
    output logic                  fdc_dma_write,
    output logic                  par_dma_read,
    output logic                  par_dma_write,
    output logic                  tc_accepted,
    output logic                  irq_out
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Drive an interrupt line: polarity on driven level only
    function automatic idi_pkg::idi_pin_s line(input logic act, input logic en,
                                               input logic pol_high);
        idi_pkg::idi_pin_s p;
        p.out  = en ? (act ~^ pol_high) : 1'b0;
        p.oe_n = ~en;
        return p;
    endfunction : line

    // Hardware config: 2xx serial bases belong to line 3
    function automatic logic ser_on3(input logic [1:0] base);
        return (base == idi_pkg::SER_2F8) || (base == idi_pkg::SER_2E8);
    endfunction : ser_on3

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    idi_pkg::idi_isa_s sync1_q, sync2_q;

    // Two flops before any logic reads the ISA pins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 6'h33; // Idle pin levels: acks and strobes high
            sync2_q <= 6'h33;
        end else begin
            sync1_q <= isa_pins;
            sync2_q <= sync1_q;
        end
    end

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    logic [7:0] ctrl_q, ctrl_d, cfg2_q, cfg2_d, pcf1_q, pcf1_d, scfg_q, scfg_d;
    logic [2:0] sts_q, sts_d, msk_q, msk_d, ev;
    logic [7:0] rdata_q, rdata_d;
    logic [7:0] live;
    logic       gate, ecp, xdma, swc;

    assign gate = ctrl_q[idi_pkg::CTRL_FDC_GATE];
    assign ecp  = ctrl_q[idi_pkg::CTRL_ECP_MODE];
    assign xdma = ctrl_q[idi_pkg::CTRL_EXT_DMA];
    assign swc  = ctrl_q[idi_pkg::CTRL_SW_CFG];

    // Writes, sticky status with set winning over clear, read mux
    always_comb begin
        ctrl_d  = ctrl_q;
        cfg2_d  = cfg2_q;
        pcf1_d  = pcf1_q;
        scfg_d  = scfg_q;
        msk_d   = msk_q;
        sts_d   = sts_q;
        rdata_d = 8'h00;
        if (reg_write) begin
            unique case (reg_addr)
                idi_pkg::OFF_CTRL: ctrl_d = reg_wdata;
                idi_pkg::OFF_CFG2: cfg2_d = reg_wdata;
                idi_pkg::OFF_PCF1: pcf1_d = reg_wdata;
                idi_pkg::OFF_SCFG: scfg_d = reg_wdata;
                idi_pkg::OFF_STS:  sts_d  = sts_q & ~reg_wdata[2:0];
                idi_pkg::OFF_MSK:  msk_d  = reg_wdata[2:0];
                default: ;
            endcase
        end
        sts_d = sts_d | ev;
        if (reg_read) begin
            unique case (reg_addr)
                idi_pkg::OFF_CTRL: rdata_d = ctrl_q;
                idi_pkg::OFF_CFG2: rdata_d = cfg2_q;
                idi_pkg::OFF_PCF1: rdata_d = pcf1_q;
                idi_pkg::OFF_SCFG: rdata_d = scfg_q;
                idi_pkg::OFF_STS:  rdata_d = {5'h00, sts_q};
                idi_pkg::OFF_MSK:  rdata_d = {5'h00, msk_q};
                idi_pkg::OFF_LIVE: rdata_d = live;
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q  <= idi_pkg::RST_CTRL;
            cfg2_q  <= idi_pkg::RST_CFG2;
            pcf1_q  <= idi_pkg::RST_PCF1;
            scfg_q  <= idi_pkg::RST_SCFG;
            sts_q   <= idi_pkg::RST_EV;
            msk_q   <= idi_pkg::RST_EV;
            rdata_q <= 8'h00;
        end else begin
            ctrl_q  <= ctrl_d;
            cfg2_q  <= cfg2_d;
            pcf1_q  <= pcf1_d;
            scfg_q  <= scfg_d;
            sts_q   <= sts_d;
            msk_q   <= msk_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------
    // DMA handshake
    // ------------------------------------------------------------
    logic fack, pack, fdma, pdma, tc_d;
    logic fdrd_d, fdwr_d, pdrd_d, pdwr_d, zwe_act;
    idi_pkg::idi_pin_s fdreq_d, ppreq_d, zwe_d;

    // Acks count only while their gate enables them
    always_comb begin
        fack     = !sync2_q.floppy_dma_ack_n && gate;          // R2
        pack     = !sync2_q.parport_dma_ack_n && ecp && xdma;  // R5
        fdma     = sync2_q.aen && fack;                        // R16
        pdma     = sync2_q.aen && pack;                        // R16
        fdrd_d   = fdma && !sync2_q.iorc_n;                    // R2
        fdwr_d   = fdma && !sync2_q.iowc_n;
        pdrd_d   = pdma && !sync2_q.iorc_n;                    // R5
        pdwr_d   = pdma && !sync2_q.iowc_n;
        tc_d     = sync2_q.tc && (fack || pack);               // R6
        zwe_act  = !sync2_q.aen && io_decoded && !fack && !pack
                   && (!sync2_q.iorc_n || !sync2_q.iowc_n);    // R17
        zwe_d.out  = 1'b0;
        zwe_d.oe_n = !zwe_act;
        fdreq_d.out  = gate && fdc_dma_want;                   // R1
        fdreq_d.oe_n = !gate;                                  // R1
        if (!ecp) begin
            ppreq_d.out  = 1'b0;                               // R3
            ppreq_d.oe_n = 1'b0;
        end else begin
            ppreq_d.out  = xdma && par_dma_want;               // R4
            ppreq_d.oe_n = !xdma;                              // R4
        end
        ev = idi_pkg::RST_EV;
        ev[idi_pkg::EV_TC]   = tc_d;
        ev[idi_pkg::EV_FDMA] = fdrd_d || fdwr_d;
        ev[idi_pkg::EV_PDMA] = pdrd_d || pdwr_d;
    end

    // ------------------------------------------------------------
    // Interrupt line steering
    // ------------------------------------------------------------
    logic a3, b3, l3_act, l3_en, l4_act, l4_en, p7, f_act;
    idi_pkg::idi_pin_s i3_d, i4_d, i5_d, i6_d, i7_d;

    // Serial on 3/4, parallel on 5/7, floppy on 6
    always_comb begin
        a3 = swc ? scfg_q[idi_pkg::SCFG_A_IRQ3] : ser_on3(ser_a_base); // R8 R9
        b3 = swc ? scfg_q[idi_pkg::SCFG_B_IRQ3] : ser_on3(ser_b_base); // R8 R9
        l3_en  = (a3 && ser_a_out2) || (b3 && ser_b_out2);             // R10
        l4_en  = (!a3 && ser_a_out2) || (!b3 && ser_b_out2);           // R10
        l3_act = (a3 && ser_a_out2 && ser_a_irq) || (b3 && ser_b_out2 && ser_b_irq);
        l4_act = (!a3 && ser_a_out2 && ser_a_irq) || (!b3 && ser_b_out2 && ser_b_irq);
        i3_d = line(l3_act, l3_en, cfg2_q[idi_pkg::CFG2_SER_POL]);     // R7 R18
        i4_d = line(l4_act, l4_en, cfg2_q[idi_pkg::CFG2_SER_POL]);     // R7 R18
        p7 = swc ? pcf1_q[idi_pkg::PCF1_SEL7]
                 : (par_base != idi_pkg::PAR_278);                     // R12
        i5_d = line(par_irq, pcf1_q[idi_pkg::PCF1_EN] && !p7,
                    cfg2_q[idi_pkg::CFG2_PAR_POL]);                    // R11
        i7_d = line(par_irq, pcf1_q[idi_pkg::PCF1_EN] && p7,
                    cfg2_q[idi_pkg::CFG2_PAR_POL]);                    // R11
        f_act = (fdc_non_dma && fdc_data_ready) || fdc_exec_done;      // R13 R14
        i6_d  = line(f_act, gate, cfg2_q[idi_pkg::CFG2_FDC_POL]);      // R15
        live = {1'b0, fack, pack, sync2_q.aen, ppreq_d.out, fdreq_d.out,
                f_act, par_irq};
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Every top output leaves from a flop; lines idle tri-stated, except the parallel request, which reset drives low
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            floppy_dma_request  <= 2'h1;
            parport_dma_request <= 2'h0;
            irq3            <= 2'h1;
            irq4            <= 2'h1;
            irq5            <= 2'h1;
            irq6            <= 2'h1;
            irq7            <= 2'h1;
            zero_wait_end_n <= 2'h1;
            fdc_dma_read    <= 1'b0;
            fdc_dma_write   <= 1'b0;
            par_dma_read    <= 1'b0;
            par_dma_write   <= 1'b0;
            tc_accepted     <= 1'b0;
            irq_out         <= 1'b0;
        end else begin
            floppy_dma_request  <= fdreq_d;
            parport_dma_request <= ppreq_d;
            irq3            <= i3_d;
            irq4            <= i4_d;
            irq5            <= i5_d;
            irq6            <= i6_d;
            irq7            <= i7_d;
            zero_wait_end_n <= zwe_d;
            fdc_dma_read    <= fdrd_d;
            fdc_dma_write   <= fdwr_d;
            par_dma_read    <= pdrd_d;
            par_dma_write   <= pdwr_d;
            tc_accepted     <= tc_d;
            irq_out         <= |(sts_d & msk_d);
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_fdma_rd;
        sync2_q.aen && !sync2_q.floppy_dma_ack_n && gate && !sync2_q.iorc_n;
    endsequence
    sequence s_any_dma;
        sync2_q.aen && (fack || pack);
    endsequence

    a_fdreq_gate: assert property (!gate |=> floppy_dma_request.oe_n) // R1
        else $error("Floppy request driven while gate clear");
    a_fdma_read: assert property (s_fdma_rd |=> fdc_dma_read) // R2
        else $error("Floppy DMA read not issued");
    a_ppreq_mode: assert property (!ecp |=> !parport_dma_request.out
                                   && !parport_dma_request.oe_n) // R3
        else $error("Parallel request not negated outside ECP");
    a_ppreq_xctl: assert property (ecp && !xdma |=> parport_dma_request.oe_n) // R4
        else $error("Parallel request driven with extended DMA bit clear");
    a_pdma_gate: assert property (par_dma_read || par_dma_write |-> $past(xdma)) // R5
        else $error("Parallel DMA strobe without ECP_EXTENDED_CONTROL_REG enable");
    a_tc_qualify: assert property (tc_accepted |-> $past(fack || pack)) // R6
        else $error("Terminal count taken without ack");
    a_irq7_unsel: assert property (!p7 |=> irq7.oe_n) // R11
        else $error("Unselected parallel line driven");
    a_irq6_gate: assert property (!gate |=> irq6.oe_n && irq6.out == 1'b0) // R15
        else $error("Floppy line driven with gate clear");
    a_zwe_dma: assert property (s_any_dma |=> zero_wait_end_n.oe_n ##1
                                $past(zwe_act) == !zero_wait_end_n.oe_n) // R17
        else $error("Zero-wait end asserted in DMA cycle");
    a_irq6_level: assert property (gate && f_act |=> !irq6.oe_n
                                   && irq6.out == $past(cfg2_q[2])) // R13
        else $error("Floppy line level wrong");
    a_irq_sticky: assert property (ev[0] |=> sts_q[0] [*2] or
                                   (sts_q[0] ##1 $past(reg_write))) // R6
        else $error("Terminal count event lost");
endmodule : idi_dma_irq
`default_nettype wire

// [idi_pkg.sv]
// Purpose: Shared constants and carriers for the DMA/IRQ pin logic
// Assumes: Plain 3-bit register port, 8-bit data
// Notes:   Offsets, bit positions and reset values live here
package idi_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] OFF_CTRL = 3'h0; // Gate and mode bits
    localparam logic [2:0] OFF_CFG2 = 3'h1; // chip_config_reg_two
    localparam logic [2:0] OFF_PCF1 = 3'h2; // parport_config_reg_one
    localparam logic [2:0] OFF_SCFG = 3'h3; // Serial line steering
    localparam logic [2:0] OFF_STS  = 3'h4; // Sticky events, write one to clear
    localparam logic [2:0] OFF_MSK  = 3'h5; // Event mask
    localparam logic [2:0] OFF_LIVE = 3'h6; // Live pin state

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int CTRL_ECP_MODE = 0; // Parallel port in ECP hardware mode
    localparam int CTRL_SW_CFG   = 1; // Software configuration in force
    localparam int CTRL_FDC_GATE = 3; // dma_irq_gate_bit of disk_output_control_reg
    localparam int CTRL_EXT_DMA  = 4; // Bit 3 of ecp_extended_control_reg
    localparam int CFG2_SER_POL  = 0; // 1: serial lines active high
    localparam int CFG2_PAR_POL  = 1; // 1: parallel line active high
    localparam int CFG2_FDC_POL  = 2; // 1: floppy line active high
    localparam int PCF1_SEL7     = 0; // 0: line 5, 1: line 7
    localparam int PCF1_EN       = 1; // Parallel interrupt enable
    localparam int SCFG_A_IRQ3   = 0; // Port A onto line 3 (else 4)
    localparam int SCFG_B_IRQ3   = 1; // Port B onto line 3 (else 4)
    localparam int EV_TC         = 0; // Qualified terminal count
    localparam int EV_FDMA       = 1; // Floppy DMA cycle seen
    localparam int EV_PDMA       = 2; // Parallel DMA cycle seen

    // ------------------------------------------------------------
    // Reset values and base address codes
    // ------------------------------------------------------------
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] RST_CFG2 = 8'h07;
    localparam logic [7:0] RST_PCF1 = 8'h00;
    localparam logic [7:0] RST_SCFG = 8'h00;
    localparam logic [2:0] RST_EV   = 3'h0;
    localparam logic [1:0] SER_3F8  = 2'h0;
    localparam logic [1:0] SER_2F8  = 2'h1;
    localparam logic [1:0] SER_3E8  = 2'h2;
    localparam logic [1:0] SER_2E8  = 2'h3;
    localparam logic [1:0] PAR_378  = 2'h0;
    localparam logic [1:0] PAR_278  = 2'h1;
    localparam logic [1:0] PAR_3BC  = 2'h2;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic out;   // Level driven when enabled
        logic oe_n;  // Low while driving
    } idi_pin_s;

    typedef struct packed {
        logic floppy_dma_ack_n;
        logic parport_dma_ack_n;
        logic tc;
        logic aen;
        logic iorc_n;
        logic iowc_n;
    } idi_isa_s;
endpackage : idi_pkg

// [idi_isa_host.sv]
// Purpose: System DMA controller model on the ISA side of the pin logic
// Assumes: One burst of n transfers answers one driven request
// Notes:   rogue answers with no request pending, for refusal tests; pio runs plain I/O cycles
`timescale 1ns/1ps
`default_nettype none
module idi_isa_host (
    input  wire logic              clk,
    input  wire idi_pkg::idi_pin_s fd_req,
    input  wire idi_pkg::idi_pin_s pp_req,
    input  wire logic              go,
    input  wire logic              par,
    input  wire logic              wr,
    input  wire logic              rogue,
    input  wire logic              pio,
    input  wire logic [1:0]        n,
    output idi_pkg::idi_isa_s      isa,
    output logic                   busy
);
    idi_pkg::idi_pin_s req;
    int                i;
    // Idle bus first, then per go wait for a driven request and run the burst, TC on the last
    initial begin
        isa = '{1'h1, 1'h1, 1'h0, 1'h0, 1'h1, 1'h1};
        busy = 1'h0;
        forever begin
            @(posedge clk);
            if (go) begin
                busy <= 1'h1;
                req = par ? pp_req : fd_req;
                while (!rogue && !(req.oe_n === 1'h0 && req.out === 1'h1)) begin
                    @(posedge clk);
                    req = par ? pp_req : fd_req;
                end
                // A plain I/O cycle keeps both acks and AEN negated
                for (i = 0; i < int'(n); i++) begin
                    isa.floppy_dma_ack_n <= par || pio;
                    isa.parport_dma_ack_n <= !par || pio;
                    isa.aen <= !pio;
                    isa.tc <= (i == int'(n) - 1);
                    isa.iorc_n <= wr;
                    isa.iowc_n <= !wr;
                    repeat (4) @(posedge clk);
                    isa.iorc_n <= 1'h1;
                    isa.iowc_n <= 1'h1;
                    isa.tc <= 1'h0;
                    @(posedge clk);
                end
                isa.floppy_dma_ack_n <= 1'h1;
                isa.parport_dma_ack_n <= 1'h1;
                isa.aen <= 1'h0;
                busy <= 1'h0;
            end
        end
    end
endmodule : idi_isa_host
`default_nettype wire

// [idi_tb.sv]
// Purpose: Self-checking bench for the DMA and interrupt pin logic
// Assumes: Outputs read at a clock edge, before that edge's updates
// Notes:   ISA pins come from the host model, core side from the bench
`timescale 1ns/1ps
`default_nettype none
module tb;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic              clk, rst_n, reg_write, reg_read, io_decoded, par_irq, fdc_dma_want, fdc_non_dma;
    logic              fdc_data_ready, fdc_exec_done, par_dma_want, ser_a_irq, ser_a_out2, ser_b_irq;
    logic              ser_b_out2, go, par, wr, rogue, pio, busy, clr, fdc_dma_read, fdc_dma_write;
    logic              par_dma_read, par_dma_write, tc_accepted, irq_out;
    logic [1:0]        ser_a_base, ser_b_base, par_base, n;
    logic [2:0]        reg_addr;
    logic [7:0]        reg_wdata, reg_rdata, seen;
    idi_pkg::idi_isa_s isa_pins;
    idi_pkg::idi_pin_s floppy_dma_request, parport_dma_request, irq3, irq4, irq5, irq6, irq7, zero_wait_end_n;
    int                mismatches, tests_run, i;

    idi_dma_irq uut (.clk, .rst_n, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .isa_pins,
        .io_decoded, .fdc_dma_want, .fdc_non_dma, .fdc_data_ready, .fdc_exec_done, .par_dma_want, .par_irq,
        .ser_a_irq, .ser_a_out2, .ser_a_base, .ser_b_irq, .ser_b_out2, .ser_b_base, .par_base,
        .floppy_dma_request, .parport_dma_request, .irq3, .irq4, .irq5, .irq6, .irq7, .zero_wait_end_n,
        .fdc_dma_read, .fdc_dma_write, .par_dma_read, .par_dma_write, .tc_accepted, .irq_out);
    idi_isa_host host (.clk, .fd_req(floppy_dma_request), .pp_req(parport_dma_request), .go, .par, .wr,
        .rogue, .pio, .n, .isa(isa_pins), .busy);

    // 50 MHz clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end
    // Sticky record of DMA strobes, TC and zero-wait end seen in a burst
    always @(posedge clk) begin
        seen <= clr ? 8'h00 : seen | {2'h0, ~zero_wait_end_n.oe_n, tc_accepted, par_dma_write, par_dma_read,
            fdc_dma_write, fdc_dma_read};
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // Enable and, while driven, the level of a pin
    task automatic pin(input idi_pkg::idi_pin_s p, input logic oe_n, input logic lvl);
        chk({7'h00, p.oe_n}, {7'h00, oe_n});
        if (!oe_n) chk({7'h00, p.out}, {7'h00, lvl});
    endtask : pin
    // Long enough for pin sync and output flops
    task automatic s();
        repeat (4) @(posedge clk);
    endtask : s
    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'h1;
        @(posedge clk);
        reg_write <= 1'h0;
    endtask : wreg
    task automatic rreg(input logic [2:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'h1;
        @(posedge clk);
        reg_read <= 1'h0;
        @(posedge clk);
        chk(reg_rdata, e);
    endtask : rreg
    // One burst by the host model, then compare the record of what was seen
    task automatic dma(input logic p, input logic w, input logic r, input logic [1:0] c, input logic [7:0] e);
        int k;
        @(posedge clk);
        {clr, go, par, wr, rogue, n} <= {1'h1, 1'h1, p, w, r, c};
        @(posedge clk);
        {clr, go} <= 2'h0;
        for (k = 0; (busy !== 1'h0 || k < 2) && k < 300; k++) @(posedge clk);
        s();
        chk(seen, e);
    endtask : dma
    task automatic end_of_test();
        $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : end_of_test

    // Watchdog well beyond the expected run
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, reg_write, reg_read, io_decoded, par_irq, fdc_dma_want, fdc_non_dma, fdc_data_ready} = '0;
        {fdc_exec_done, par_dma_want, ser_a_irq, ser_a_out2, ser_b_irq, ser_b_out2, go, par, wr, rogue} = '0;
        {clr, pio, ser_a_base, ser_b_base, par_base, n, reg_addr, reg_wdata} = '0;
        mismatches = 0;
        tests_run = 0;
        repeat (8) @(posedge clk);
        rst_n <= 1'h1;
        for (i = 0; i < 8; i++) if (i != 6) rreg(i[2:0], i == 1 ? idi_pkg::RST_CFG2 : 8'h00);
        wreg(3'h7, 8'hff);
        rreg(3'h7, 8'h00);
        pin(parport_dma_request, 1'h0, 1'h0);
        $display("test reset done");
        fdc_dma_want <= 1'h1;
        fdc_non_dma <= 1'h1;
        fdc_data_ready <= 1'h1;
        s();
        pin(floppy_dma_request, 1'h1, 1'h0);
        pin(irq6, 1'h1, 1'h0);
        wreg(3'h0, 8'h08);
        s();
        pin(floppy_dma_request, 1'h0, 1'h1);
        pin(irq6, 1'h0, 1'h1);
        wreg(3'h1, 8'h03);
        fdc_data_ready <= 1'h0;
        s();
        pin(irq6, 1'h0, 1'h1);
        fdc_exec_done <= 1'h1;
        s();
        pin(irq6, 1'h0, 1'h0);
        wreg(3'h0, 8'h00);
        s();
        pin(irq6, 1'h1, 1'h0);
        $display("test floppy lines done");
        wreg(3'h0, 8'h08);
        wreg(3'h5, 8'h07);
        io_decoded <= 1'h1;
        dma(1'h0, 1'h0, 1'h0, 2'h2, 8'h11);
        dma(1'h0, 1'h1, 1'h0, 2'h1, 8'h12);
        rreg(3'h4, 8'h03);
        chk({7'h00, irq_out}, 8'h01);
        wreg(3'h5, 8'h00);
        s();
        chk({7'h00, irq_out}, 8'h00);
        wreg(3'h5, 8'h07);
        wreg(3'h4, 8'h01);
        rreg(3'h4, 8'h02);
        wreg(3'h4, 8'h02);
        rreg(3'h4, 8'h00);
        chk({7'h00, irq_out}, 8'h00);
        wreg(3'h0, 8'h00);
        dma(1'h0, 1'h0, 1'h1, 2'h1, 8'h00);
        dma(1'h1, 1'h1, 1'h1, 2'h1, 8'h00);
        pio <= 1'h1;
        dma(1'h0, 1'h0, 1'h1, 2'h1, 8'h20);
        pio <= 1'h0;
        rreg(3'h4, 8'h00);
        $display("test dma and status done");
        par_dma_want <= 1'h1;
        s();
        pin(parport_dma_request, 1'h0, 1'h0);
        wreg(3'h0, 8'h01);
        s();
        pin(parport_dma_request, 1'h1, 1'h0);
        wreg(3'h0, 8'h11);
        s();
        pin(parport_dma_request, 1'h0, 1'h1);
        dma(1'h1, 1'h1, 1'h0, 2'h1, 8'h18);
        rreg(3'h4, 8'h05);
        $display("test parallel dma done");
        wreg(3'h0, 8'h00);
        ser_a_irq <= 1'h1;
        ser_a_out2 <= 1'h1;
        for (i = 0; i < 4; i++) begin
            ser_a_base <= i[1:0];
            s();
            pin(irq3, !i[0], 1'h1);
            pin(irq4, i[0], 1'h1);
        end
        ser_a_out2 <= 1'h0;
        s();
        pin(irq3, 1'h1, 1'h0);
        ser_a_out2 <= 1'h1;
        wreg(3'h1, 8'h02);
        s();
        pin(irq3, 1'h0, 1'h0);
        ser_a_irq <= 1'h0;
        s();
        pin(irq3, 1'h0, 1'h1);
        wreg(3'h0, 8'h02);
        wreg(3'h3, 8'h00);
        s();
        pin(irq4, 1'h0, 1'h1);
        pin(irq3, 1'h1, 1'h0);
        $display("test serial lines done");
        wreg(3'h0, 8'h00);
        wreg(3'h1, 8'h07);
        wreg(3'h2, 8'h02);
        par_irq <= 1'h1;
        for (i = 0; i < 3; i++) begin
            par_base <= i[1:0];
            s();
            pin(irq5, i != 1, 1'h1);
            pin(irq7, i == 1, 1'h1);
        end
        wreg(3'h0, 8'h02);
        wreg(3'h1, 8'h05);
        s();
        pin(irq5, 1'h0, 1'h0);
        pin(irq7, 1'h1, 1'h0);
        wreg(3'h2, 8'h01);
        s();
        pin(irq5, 1'h1, 1'h0);
        pin(irq7, 1'h1, 1'h0);
        rreg(3'h6, 8'h03);
        $display("test parallel lines done");
        end_of_test();
    end
endmodule : tb
`default_nettype wire
